// file: logic/ppe_pkg.sv
// constants for the port p pull and edge interrupt block
package ppe_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_PIN_DIRECTION = 8'h1a;
	localparam logic [7:0] IDX_PULL_ENABLE = 8'h1c;
	localparam logic [7:0] IDX_POLARITY_SELECT = 8'h1d;
	localparam logic [7:0] IDX_PIN_INTERRUPT_ENABLE = 8'h1e;
	localparam logic [7:0] IDX_PIN_INTERRUPT_FLAGS = 8'h1f;
	localparam logic [7:0] IDX_FLAG_CLEAR = 8'h20;
	// byte addresses on the apb address bus
	localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h68;
	localparam logic [7:0] ADDR_PULL_ENABLE = 8'h70;
	localparam logic [7:0] ADDR_POLARITY_SELECT = 8'h74;
	localparam logic [7:0] ADDR_PIN_INTERRUPT_ENABLE = 8'h78;
	localparam logic [7:0] ADDR_PIN_INTERRUPT_FLAGS = 8'h7c;
	localparam logic [7:0] ADDR_FLAG_CLEAR = 8'h80;
	// widths
	localparam int PIN_COUNT = 8;
	localparam int ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 32;
	// reset values
	localparam logic [7:0] RST_PIN_DIRECTION = 8'h00;
	localparam logic [7:0] RST_PULL_ENABLE = 8'h00;
	localparam logic [7:0] RST_POLARITY_SELECT = 8'h00;
	localparam logic [7:0] RST_PIN_INTERRUPT_ENABLE = 8'h00;
	localparam logic [7:0] RST_PIN_INTERRUPT_FLAGS = 8'h00;
	// polarity encoding: 0 falling edge with pull-up, 1 rising with pull-down
	localparam logic POL_FALLING = 1'b0;
	localparam logic POL_RISING = 1'b1;
	// direction encoding
	localparam logic DIR_INPUT = 1'b0;
	localparam logic DIR_OUTPUT = 1'b1;
endpackage : ppe_pkg

// file: logic/ppe_sync.sv
// two flip-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ns
module ppe_sync #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	import ppe_pkg::*;

	logic [WIDTH-1:0] stage1; // metastable stage, read only by stage two
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_sync_out;

	// next values: plain shift through two stages
	always_comb begin
		next_stage1 = async_in;
		next_sync_out = stage1;
	end

	// registers; the reset low level is not a real pin sample, so the edge
	// logic downstream stays blind until both stages and the edge history have refilled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= next_stage1;
			sync_out <= next_sync_out;
		end
	end
endmodule : ppe_sync

// file: logic/ppe_top.sv
// port p pull control and edge interrupt block with apb register slave
// Functional notes
// - pull acts only while pin is input
// - all pulls disabled after reset
// - falling polarity: falling edge flags, pull-up
// - rising polarity: rising edge flags, pull-down
// - enable bit masks or passes flag
// - active edge sets flag, sticky until cleared
// - write one clears flag, zero no effect
// - irq while any enabled flag set
// - flag one means edge since clear
// - direction zero input, one output, gates behaviour
`timescale 1ns/1ns
module ppe_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ppe_pkg::ADDR_WIDTH-1:0] paddr,
	input wire logic [ppe_pkg::DATA_WIDTH-1:0] pwdata,
	output logic [ppe_pkg::DATA_WIDTH-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [ppe_pkg::PIN_COUNT-1:0] pin_in,
	output logic [ppe_pkg::PIN_COUNT-1:0] pin_direction_out,
	output logic [ppe_pkg::PIN_COUNT-1:0] pull_up_en,
	output logic [ppe_pkg::PIN_COUNT-1:0] pull_down_en,
	output logic irq
);
	import ppe_pkg::*;

	// software-visible state
	logic [7:0] pin_direction; // 1 = output
	logic [7:0] pull_enable; // per-pin pull device enable
	logic [7:0] polarity_select; // edge polarity and pull kind
	logic [7:0] pin_interrupt_enable; // per-pin flag mask
	logic [7:0] pin_interrupt_flags; // sticky edge flags
	logic [7:0] next_pin_direction;
	logic [7:0] next_pull_enable;
	logic [7:0] next_polarity_select;
	logic [7:0] next_pin_interrupt_enable;
	logic [7:0] next_pin_interrupt_flags;

	// bus side
	logic [DATA_WIDTH-1:0] next_prdata;
	logic wr_access; // access phase of a write
	logic rd_setup; // setup phase of a read; data captured here
	logic addr_hit; // address maps to a register
	logic [7:0] clr_vec; // flags to clear this cycle

	// pin side
	logic [7:0] pin_sync; // synchronised pin levels
	logic [7:0] pin_prev; // previous synchronised level
	logic [7:0] next_pin_prev;
	logic [7:0] rise_vec; // rising edges on synchronised pins
	logic [7:0] fall_vec; // falling edges on synchronised pins
	logic [7:0] in_mask; // pins configured as input
	logic [7:0] set_fall; // qualified falling-edge events
	logic [7:0] set_rise; // qualified rising-edge events
	logic [7:0] set_vec; // all qualified events
	logic [2:0] hist_warm; // fills with ones as real pin samples arrive
	logic [2:0] next_hist_warm;
	logic [7:0] armed; // all ones once the edge history is real

	// synchronise all pins before any edge logic looks at them
	ppe_sync #(
		.WIDTH(PIN_COUNT)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_access = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;

	// address decode for the error response only; read and write decode paddr themselves
	always_comb begin
		if (paddr == ADDR_PIN_DIRECTION) begin
			addr_hit = 1'b1;
		end else if (paddr == ADDR_PULL_ENABLE) begin
			addr_hit = 1'b1;
		end else if (paddr == ADDR_POLARITY_SELECT) begin
			addr_hit = 1'b1;
		end else if (paddr == ADDR_PIN_INTERRUPT_ENABLE) begin
			addr_hit = 1'b1;
		end else if (paddr == ADDR_PIN_INTERRUPT_FLAGS) begin
			addr_hit = 1'b1;
		end else if (paddr == ADDR_FLAG_CLEAR) begin
			addr_hit = 1'b1;
		end else begin
			addr_hit = 1'b0;
		end
	end

	// unmapped addresses answer with an error in the access phase
	assign pslverr = psel & penable & ~addr_hit;

	// read data is registered in the setup phase so prdata is a flop
	always_comb begin
		next_prdata = prdata;
		if (rd_setup) begin
			next_prdata = '0;
			if (paddr == ADDR_PIN_DIRECTION) begin
				next_prdata[7:0] = pin_direction;
			end else if (paddr == ADDR_PULL_ENABLE) begin
				next_prdata[7:0] = pull_enable;
			end else if (paddr == ADDR_POLARITY_SELECT) begin
				next_prdata[7:0] = polarity_select;
			end else if (paddr == ADDR_PIN_INTERRUPT_ENABLE) begin
				next_prdata[7:0] = pin_interrupt_enable;
			end else if (paddr == ADDR_PIN_INTERRUPT_FLAGS) begin
				next_prdata[7:0] = pin_interrupt_flags;
			end else begin
				// clear register is write-only and reads zero
				next_prdata = '0;
			end
		end
	end

	// control register writes; only the low byte is implemented
	always_comb begin
		next_pin_direction = pin_direction;
		next_pull_enable = pull_enable;
		next_polarity_select = polarity_select;
		next_pin_interrupt_enable = pin_interrupt_enable;
		if (wr_access) begin
			if (paddr == ADDR_PIN_DIRECTION) begin
				next_pin_direction = pwdata[7:0];
			end else if (paddr == ADDR_PULL_ENABLE) begin
				next_pull_enable = pwdata[7:0];
			end else if (paddr == ADDR_POLARITY_SELECT) begin
				next_polarity_select = pwdata[7:0];
			end else if (paddr == ADDR_PIN_INTERRUPT_ENABLE) begin
				next_pin_interrupt_enable = pwdata[7:0];
			end
		end
	end

	// write-one-to-clear; flags register and clear register act alike
	always_comb begin
		clr_vec = 8'h00;
		if (wr_access) begin
			if (paddr == ADDR_PIN_INTERRUPT_FLAGS) begin
				clr_vec = pwdata[7:0];
			end else if (paddr == ADDR_FLAG_CLEAR) begin
				clr_vec = pwdata[7:0];
			end
		end
	end

	// edge detection on synchronised levels, one pulse per transition
	// a pin held high through reset would otherwise look like a rising edge
	// while the two sync stages and the history refill from their zeros
	always_comb begin
		next_pin_prev = pin_sync;
		next_hist_warm = {hist_warm[1:0], 1'b1};
		armed = {8{hist_warm[2]}};
		rise_vec = pin_sync & ~pin_prev;
		fall_vec = ~pin_sync & pin_prev;
		in_mask = ~pin_direction;
		set_fall = fall_vec & ~polarity_select & in_mask & armed;
		set_rise = rise_vec & polarity_select & in_mask & armed;
		set_vec = set_fall | set_rise;
	end

	// sticky flags; an edge in the same cycle as its clear still sets
	always_comb begin
		next_pin_interrupt_flags =
			(pin_interrupt_flags & ~clr_vec) | set_vec;
	end

	// pull devices follow enable, polarity and direction combinationally
	always_comb begin
		pull_up_en = pull_enable & ~polarity_select & in_mask;
		pull_down_en = pull_enable & polarity_select & in_mask;
	end

	// level interrupt while any unmasked flag stands
	assign irq = |(pin_interrupt_flags & pin_interrupt_enable);
	assign pin_direction_out = pin_direction;

	// registers of all state groups; defined values from reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_direction <= RST_PIN_DIRECTION;
			pull_enable <= RST_PULL_ENABLE;
			polarity_select <= RST_POLARITY_SELECT;
			pin_interrupt_enable <= RST_PIN_INTERRUPT_ENABLE;
			pin_interrupt_flags <= RST_PIN_INTERRUPT_FLAGS;
			pin_prev <= '0;
			hist_warm <= '0;
			prdata <= '0;
		end else begin
			pin_direction <= next_pin_direction;
			pull_enable <= next_pull_enable;
			polarity_select <= next_polarity_select;
			pin_interrupt_enable <= next_pin_interrupt_enable;
			pin_interrupt_flags <= next_pin_interrupt_flags;
			pin_prev <= next_pin_prev;
			hist_warm <= next_hist_warm;
			prdata <= next_prdata;
		end
	end

	// no pull device may act on an output pin
	property p_pull_output_off;
		@(posedge pclk) disable iff (!presetn)
		((pull_up_en | pull_down_en) & pin_direction) == 8'h00;
	endproperty
	a_pull_output_off: assert property (p_pull_output_off)
		else $error("pull active on output pin");

	// first edge out of reset shows no pull device
	property p_reset_pulls_off;
		@(posedge pclk)
		$rose(presetn) |-> (pull_up_en | pull_down_en) == 8'h00;
	endproperty
	a_reset_pulls_off: assert property (p_reset_pulls_off)
		else $error("pull enabled after reset");

	// a qualified falling edge is flagged on the next edge
	property p_fall_sets;
		@(posedge pclk) disable iff (!presetn)
		(set_fall != 8'h00) |=> ($past(set_fall) & ~pin_interrupt_flags)
			== 8'h00;
	endproperty
	a_fall_sets: assert property (p_fall_sets)
		else $error("falling edge not flagged");

	// a qualified rising edge is flagged on the next edge
	property p_rise_sets;
		@(posedge pclk) disable iff (!presetn)
		(set_rise != 8'h00) |=> ($past(set_rise) & ~pin_interrupt_flags)
			== 8'h00;
	endproperty
	a_rise_sets: assert property (p_rise_sets)
		else $error("rising edge not flagged");

	// fully masked flags never raise the interrupt
	property p_mask_blocks;
		@(posedge pclk) disable iff (!presetn)
		((pin_interrupt_flags & pin_interrupt_enable) == 8'h00) |-> !irq;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks)
		else $error("masked flag raised interrupt");

	// a set flag without a clear stays set
	property p_flag_sticky;
		@(posedge pclk) disable iff (!presetn)
		(clr_vec == 8'h00) |=> (($past(pin_interrupt_flags)
			& ~pin_interrupt_flags) == 8'h00);
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag dropped without clear");

	// written ones clear unless an edge lands in the same cycle
	property p_w1c;
		@(posedge pclk) disable iff (!presetn)
		(clr_vec != 8'h00) |=> (pin_interrupt_flags & $past(clr_vec)
			& ~$past(set_vec)) == 8'h00;
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("write one did not clear flag");

	// an enabled flag raises the interrupt
	property p_irq_raise;
		@(posedge pclk) disable iff (!presetn)
		((pin_interrupt_flags & pin_interrupt_enable) != 8'h00) |-> irq;
	endproperty
	a_irq_raise: assert property (p_irq_raise)
		else $error("enabled flag without interrupt");

	// a flag only rises after a qualified edge
	property p_flag_cause;
		@(posedge pclk) disable iff (!presetn)
		##1 ((pin_interrupt_flags & ~$past(pin_interrupt_flags)
			& ~$past(set_vec)) == 8'h00);
	endproperty
	a_flag_cause: assert property (p_flag_cause)
		else $error("flag set with no edge");

	// a pin configured as output never raises a new flag
	property p_output_no_flag;
		@(posedge pclk) disable iff (!presetn)
		##1 ((pin_interrupt_flags & ~$past(pin_interrupt_flags)
			& $past(pin_direction)) == 8'h00);
	endproperty
	a_output_no_flag: assert property (p_output_no_flag)
		else $error("output pin raised a flag");

	// one transition yields one event pulse, never two in a row
	property p_single_event;
		@(posedge pclk) disable iff (!presetn)
		(set_vec != 8'h00) |=> (set_vec & $past(set_vec)) == 8'h00;
	endproperty
	a_single_event: assert property (p_single_event)
		else $error("one edge produced two events");
endmodule : ppe_top

// file: bench/ppe_pin_model.sv
// model of the external lines on the eight port pins
`timescale 1ns/1ns
module ppe_pin_model (
	input wire logic pclk,
	input wire logic [7:0] drive_en,
	input wire logic [7:0] drive_val,
	input wire logic [7:0] pull_up_en,
	input wire logic [7:0] pull_down_en,
	output logic [7:0] pin_level
);
	logic [7:0] last_level = 8'h00; // level seen at the previous edge

	// a floating pin shows the inverse of its last level, so no stale value
	// is mistaken for a held one
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (drive_en[i]) begin
				pin_level[i] = drive_val[i];
			end else if (pull_up_en[i]) begin
				pin_level[i] = 1'b1;
			end else if (pull_down_en[i]) begin
				pin_level[i] = 1'b0;
			end else begin
				pin_level[i] = ~last_level[i];
			end
		end
	end

	// history of the line level
	always @(posedge pclk) begin
		last_level <= pin_level;
	end
endmodule : ppe_pin_model

// file: bench/ppe_top_tb.sv
// self-checking bench for the port p pull and edge interrupt block
`timescale 1ns/1ns
module ppe_top_tb;
	import ppe_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] pin_level;
	logic [7:0] drive_val = 8'hff; // pins start high so reset sees no fall
	logic [7:0] drive_en = 8'hff; // bench drives every pin at first
	logic [7:0] pin_dir;
	logic [7:0] pull_up_en;
	logic [7:0] pull_down_en;
	logic irq;
	int err_count = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] rdata;
	logic rerr;

	always #50 pclk = ~pclk;

	ppe_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_level), .pin_direction_out(pin_dir),
		.pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .irq(irq));

	ppe_pin_model pins_u (.pclk(pclk), .drive_en(drive_en),
		.drive_val(drive_val), .pull_up_en(pull_up_en),
		.pull_down_en(pull_down_en), .pin_level(pin_level));

	// compare one value and report a mismatch at once
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// one apb transfer; the request holds until pready is seen high
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	// read a register and compare it
	task automatic rd(input string name, input logic [7:0] a,
		input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(name, exp, rdata);
	endtask : rd

	// drive or release pins, then let edges pass the synchroniser
	task automatic pins(input logic [7:0] en, input logic [7:0] v);
		@(posedge pclk);
		drive_en <= en;
		drive_val <= v;
		repeat (6) @(posedge pclk);
	endtask : pins

	// verdict and end of run
	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// watchdog: the whole run needs about 110 cycles
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			summarize();
		end
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// reset state of registers and pull outputs
		rd("pull_enable", ADDR_PULL_ENABLE, 32'h0);
		rd("polarity", ADDR_POLARITY_SELECT, 32'h0);
		rd("irq_enable", ADDR_PIN_INTERRUPT_ENABLE, 32'h0);
		rd("flags", ADDR_PIN_INTERRUPT_FLAGS, 32'h0);
		rd("direction", ADDR_PIN_DIRECTION, 32'h0);
		chk("pulls", 32'h0, {16'h0, pull_up_en, pull_down_en});
		chk("irq_rst", 32'h0, {31'h0, irq});
		$display("test reset done");
		// readback, upper bits dropped, unmapped place refused
		xfer(1'b1, ADDR_PULL_ENABLE, 32'h0000_00ff);
		xfer(1'b1, ADDR_POLARITY_SELECT, 32'hffff_ff0f);
		xfer(1'b1, ADDR_PIN_DIRECTION, 32'h0000_0003);
		xfer(1'b1, ADDR_PIN_INTERRUPT_ENABLE, 32'h0000_005a);
		rd("pull_enable", ADDR_PULL_ENABLE, 32'hff);
		rd("polarity", ADDR_POLARITY_SELECT, 32'h0f);
		rd("irq_enable", ADDR_PIN_INTERRUPT_ENABLE, 32'h5a);
		rd("direction", ADDR_PIN_DIRECTION, 32'h03);
		rd("clear_reg", ADDR_FLAG_CLEAR, 32'h0);
		rd("unmapped", 8'h84, 32'h0);
		chk("slverr", 32'h1, {31'h0, rerr});
		chk("dir_out", 32'h03, {24'h0, pin_dir});
		// pulls: up where polarity 0, down where 1, none on outputs
		chk("pull_up", 32'hf0, {24'h0, pull_up_en});
		chk("pull_down", 32'h0c, {24'h0, pull_down_en});
		$display("test registers done");
		// falling edges flag polarity 0 inputs only
		xfer(1'b1, ADDR_PIN_DIRECTION, 32'h0000_0081);
		pins(8'hff, 8'h00);
		rd("flags_fall", ADDR_PIN_INTERRUPT_FLAGS, 32'h70);
		xfer(1'b1, ADDR_PIN_INTERRUPT_FLAGS, 32'h0000_0010);
		rd("flags_w1c", ADDR_PIN_INTERRUPT_FLAGS, 32'h60);
		chk("irq_on", 32'h1, {31'h0, irq});
		xfer(1'b1, ADDR_PIN_INTERRUPT_ENABLE, 32'h0000_0000);
		// the write lands on the edge xfer returns on; look once it settled
		@(negedge pclk);
		chk("irq_masked", 32'h0, {31'h0, irq});
		// rising edges flag polarity 1 inputs, older flags stay
		pins(8'hff, 8'hff);
		rd("flags_rise", ADDR_PIN_INTERRUPT_FLAGS, 32'h6e);
		xfer(1'b1, ADDR_PIN_INTERRUPT_ENABLE, 32'h0000_0002);
		@(negedge pclk);
		chk("irq_pin1", 32'h1, {31'h0, irq});
		xfer(1'b1, ADDR_FLAG_CLEAR, 32'h0000_0002);
		rd("flags_clr", ADDR_PIN_INTERRUPT_FLAGS, 32'h6c);
		chk("irq_off", 32'h0, {31'h0, irq});
		xfer(1'b1, ADDR_PIN_INTERRUPT_FLAGS, 32'h0000_00ff);
		rd("flags_all", ADDR_PIN_INTERRUPT_FLAGS, 32'h00);
		$display("test edges done");
		// released inputs sit at their pull level; that edge never flags
		pins(8'h81, 8'hff);
		chk("pin_release", 32'hf1, {24'h0, pin_level});
		rd("flags_pull", ADDR_PIN_INTERRUPT_FLAGS, 32'h00);
		$display("test pulls done");
		summarize();
	end
endmodule : ppe_top_tb
